// ===== uartrf_defs.svh
// offsets, field positions and reset values of the uart register file
`ifndef UARTRF_DEFS_SVH
`define UARTRF_DEFS_SVH
`define UARTRF_BASE0 16'h2020
`define UARTRF_BASE1 16'h2050
`define UARTRF_OFF_HOLD 4'h0
`define UARTRF_OFF_IEN 4'h1
`define UARTRF_OFF_FCTL 4'h2
`define UARTRF_OFF_FMT 4'h3
`define UARTRF_OFF_MODE 4'h4
`define UARTRF_OFF_STAT 4'h5
`define UARTRF_OFF_CMD 4'h6
`define UARTRF_OFF_BDL 4'h7
`define UARTRF_OFF_BDH 4'h8
`define UARTRF_OFF_RTO 4'h9
`define UARTRF_OFF_TTG 4'hA
`define UARTRF_IE_TXEMPTY 7
`define UARTRF_IE_TIMEOUT 6
`define UARTRF_IE_LINEERR 3
`define UARTRF_IE_BREAK 2
`define UARTRF_IE_TXRDY 1
`define UARTRF_IE_RXRDY 0
`define UARTRF_IE_MASK 8'hCF
`define UARTRF_FC_DMA 3
`define UARTRF_FC_FLUSH 1
`define UARTRF_FC_ON 0
`define UARTRF_FC_MASK 8'hC9
`define UARTRF_CMD_RXEN 7
`define UARTRF_CMD_RSTSTAT 6
`define UARTRF_CMD_TXEN 5
`define UARTRF_CMD_RESTART 4
`define UARTRF_CMD_TXRST 3
`define UARTRF_CMD_RXRST 2
`define UARTRF_RST_BYTE 8'h00
`define UARTRF_TRIG_00 5'h01
`define UARTRF_TRIG_01 5'h04
`define UARTRF_TRIG_10 5'h08
`define UARTRF_TRIG_11 5'h0E
`define UARTRF_RX_DEPTH 5'h10
`endif

// ===== uartrf_pkg.sv
// types shared by the uart register file
package uartrf_pkg;
  typedef logic [7:0] uartrf_byte_t;
  // receiver timeout sequencer
  typedef enum logic [1:0] {TO_IDLE, TO_COUNT, TO_FIRED} uartrf_to_state_t;
endpackage

// ===== uartrf_fifo.sv
// small shift fifo with valid/ready on both sides, head held in a flop
`timescale 1ns/1ns
`default_nettype none
module uartrf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic flush_in,
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in,
  output logic full_out
);
  localparam int CW = $clog2(DEPTH + 1);
  logic [DEPTH-1:0][WIDTH-1:0] q_r; // entry 0 is the head
  logic [DEPTH:0][WIDTH-1:0] ext; // zero entry above the top
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic [CW-1:0] slot; // where a push lands
  logic push;
  logic pop;
  assign ext = {{WIDTH{1'b0}}, q_r};
  assign push = in_valid_in & ~full_out;
  assign pop = out_valid_out & out_ready_in;
  assign slot = CW'(cnt_r - CW'(pop));
  assign in_ready_out = ~full_out;
  assign out_data_out = q_r[0];
  // occupancy; flush wins over traffic
  always_comb begin
    cnt_nxt = CW'(cnt_r + CW'(push) - CW'(pop));
    if (flush_in) begin
      cnt_nxt = '0;
    end
  end
  // count and the flag flops that face the ports
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r <= '0;
      out_valid_out <= 1'b0;
      full_out <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      out_valid_out <= (cnt_nxt != '0);
      full_out <= (cnt_nxt == CW'(DEPTH));
    end
  end
  // storage shifts down on pop, push writes behind the last entry
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      q_r <= '0;
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        if (push && slot == CW'(i)) begin
          q_r[i] <= in_data_in;
        end else if (pop) begin
          q_r[i] <= ext[i+1];
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== uartrf_mem.sv
// byte memory with registered, write-first read port
`timescale 1ns/1ns
`default_nettype none
module uartrf_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic we_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [WIDTH-1:0] wdata_in,
  input wire logic [AW-1:0] raddr_in,
  output logic [WIDTH-1:0] rdata_out
);
  logic [WIDTH-1:0] mem_r [DEPTH];
  // write port; no reset on the array itself
  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem_r[waddr_in] <= wdata_in;
    end
  end
  // read port bypasses a same-cycle write so the head is never stale
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= '0;
    end else if (we_in && waddr_in == raddr_in) begin
      rdata_out <= wdata_in;
    end else begin
      rdata_out <= mem_r[raddr_in];
    end
  end
endmodule
`default_nettype wire

// ===== uartrf_regs.sv
// register file, rx buffering and interrupt requests of a dual uart
`timescale 1ns/1ns
`default_nettype none
`include "uartrf_defs.svh"
// Overview of operation
// (RULE_01) two register sets at 2020h and 2050h
// (RULE_02) four-bit offset selects registers 0 to A
// (RULE_03) second set has no fifo control
// (RULE_04) tx empty irq when holding and shifter empty
// (RULE_05) timeout irq after receiver timeout elapses
// (RULE_06) line error irq on receive error
// (RULE_07) break irq on receive break
// (RULE_08) tx ready irq when holding moves out
// (RULE_09) rx irq on unread data or trigger
// (RULE_10) trigger field picks 1, 4, 8, 14
// (RULE_11) dma burst by trigger or single byte
// (RULE_12) flush bit empties the receive fifo
// (RULE_13) fifo on gives sixteen bytes, else one
// (RULE_14) offset zero reads rx, writes tx
// (RULE_15) enables and fifo control reset to zero
// (RULE_16) status command clears parity, framing, overrun
// (RULE_17) timeout counts bit periods, zero disables
module uartrf_regs (
  input wire logic REF_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic [15:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic GIE_IN,
  output logic [7:0] RDATA_OUT,
  input wire logic [1:0][7:0] RX_DATA_IN,
  input wire logic [1:0] RX_VALID_IN,
  input wire logic [1:0] RX_PARITY_ERR_IN,
  input wire logic [1:0] RX_FRAME_ERR_IN,
  input wire logic [1:0] RX_BREAK_IN,
  input wire logic [1:0] BIT_TICK_IN,
  input wire logic [1:0] TX_SHIFT_EMPTY_IN,
  input wire logic [1:0] TX_TAKE_IN,
  output logic [1:0][7:0] TX_DATA_OUT,
  output logic [1:0] TX_VALID_OUT,
  output logic [1:0] HOLD_FULL_OUT,
  output logic [1:0] IRQ_OUT,
  output logic DMA_REQ_OUT,
  output logic [1:0][7:0] LINE_FORMAT_OUT,
  output logic [1:0][7:0] CHANNEL_MODE_OUT,
  output logic [1:0][15:0] BAUD_DIV_OUT,
  output logic [1:0][7:0] GUARD_TIME_OUT,
  output logic [1:0][7:0] RX_TIMEOUT_OUT,
  output logic [1:0] RX_EN_OUT,
  output logic [1:0] TX_EN_OUT,
  output logic [1:0][3:0] LINE_CMD_OUT
);
  // set decode: upper twelve address bits match the base
  function automatic logic set_hit(input logic [15:0] a, input logic [15:0] base);
    set_hit = (a[15:4] == base[15:4]);
  endfunction
  // fill level demanded by the trigger code
  function automatic logic [4:0] trig_level(input logic [1:0] code);
    unique case (code)
      2'b00: trig_level = `UARTRF_TRIG_00;
      2'b01: trig_level = `UARTRF_TRIG_01;
      2'b10: trig_level = `UARTRF_TRIG_10;
      2'b11: trig_level = `UARTRF_TRIG_11;
    endcase
  endfunction
  logic [3:0] off; // register offset within a set
  logic [1:0] hit; // which set is addressed
  logic [1:0] wr_hit, rd_hit; // set hit qualified by the strobes
  uartrf_pkg::uartrf_byte_t ien_r [2]; // interrupt_enables
  uartrf_pkg::uartrf_byte_t fctl_r; // rx_fifo_control, first set only
  logic [1:0] rx_en_r, tx_en_r; // stored command enables
  logic [1:0][7:0] rto_r; // rx_timeout_limit
  logic [1:0][4:0] rx_cnt_r; // bytes waiting in the receiver
  logic [3:0] wr_ptr_r, rd_ptr_r, rd_ptr_nxt; // first-set store pointers
  uartrf_pkg::uartrf_byte_t hold1_r; // single-character buffer, second set
  uartrf_pkg::uartrf_byte_t mem_q; // head of the 16-byte fifo
  logic [1:0] to_flag_r, pe_r, fe_r, oe_r, brk_r, thr_rdy_r; // sticky status flags
  uartrf_pkg::uartrf_to_state_t to_state_r [2];
  logic [1:0][7:0] to_cnt_r;
  logic [1:0] rx_full, rx_push, rx_pop, rx_flush; // receive side strobes
  logic [1:0] tx_flush, tx_push, tx_pop, tx_empty; // transmit side strobes
  logic [1:0] cmd_wr, stat_clr, restart, to_fire, rx_cause; // command and event decode
  logic [4:0] trig;
  logic [7:0] rd_mux;
  assign off = ADDR_IN[3:0];
  assign hit = {set_hit(ADDR_IN, `UARTRF_BASE1), set_hit(ADDR_IN, `UARTRF_BASE0)}; // [RULE_01]
  assign wr_hit = {2{WR_IN}} & hit;
  assign rd_hit = {2{RD_IN}} & hit;
  assign trig = trig_level(fctl_r[7:6]);
  assign rd_ptr_nxt = rx_flush[0] ? 4'h0 : 4'(rd_ptr_r + 4'(rx_pop[0]));
  // per-set strobes and events
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      cmd_wr[c] = wr_hit[c] && off == `UARTRF_OFF_CMD;
      stat_clr[c] = cmd_wr[c] && WDATA_IN[`UARTRF_CMD_RSTSTAT];
      restart[c] = cmd_wr[c] && WDATA_IN[`UARTRF_CMD_RESTART];
      tx_flush[c] = cmd_wr[c] && WDATA_IN[`UARTRF_CMD_TXRST];
      tx_push[c] = wr_hit[c] && off == `UARTRF_OFF_HOLD; // [RULE_14]
      tx_pop[c] = TX_VALID_OUT[c] && TX_TAKE_IN[c];
      tx_empty[c] = ~TX_VALID_OUT[c] & TX_SHIFT_EMPTY_IN[c];
      rx_pop[c] = rd_hit[c] && off == `UARTRF_OFF_HOLD && rx_cnt_r[c] != 5'h00; // [RULE_14]
      rx_flush[c] = cmd_wr[c] && WDATA_IN[`UARTRF_CMD_RXRST];
      to_fire[c] = to_state_r[c] == uartrf_pkg::TO_COUNT && BIT_TICK_IN[c] &&
                   rto_r[c] != 8'h00 && 8'(to_cnt_r[c] + 8'h01) >= rto_r[c]; // [RULE_17]
    end
    // flush bit of the first set empties its fifo
    rx_flush[0] = rx_flush[0] ||
                  (wr_hit[0] && off == `UARTRF_OFF_FCTL && WDATA_IN[`UARTRF_FC_FLUSH]); // [RULE_12]
    // capacity is sixteen with the fifo on, one otherwise
    rx_full[0] = fctl_r[`UARTRF_FC_ON] ? (rx_cnt_r[0] >= `UARTRF_RX_DEPTH)
                                       : (rx_cnt_r[0] != 5'h00); // [RULE_13]
    rx_full[1] = (rx_cnt_r[1] != 5'h00); // [RULE_13]
    rx_push = RX_VALID_IN & ~rx_full & ~rx_flush;
    rx_cause[0] = fctl_r[`UARTRF_FC_ON] ? (rx_cnt_r[0] >= trig)
                                        : (rx_cnt_r[0] != 5'h00); // [RULE_10]
    rx_cause[1] = (rx_cnt_r[1] != 5'h00);
  end
  // control registers; the second set ignores fifo control writes
  always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      ien_r[0] <= `UARTRF_RST_BYTE; // [RULE_15]
      ien_r[1] <= `UARTRF_RST_BYTE; // [RULE_15]
      fctl_r <= `UARTRF_RST_BYTE; // [RULE_15]
      {rx_en_r, tx_en_r} <= 4'h0;
      rto_r <= '0;
      LINE_FORMAT_OUT <= '0;
      CHANNEL_MODE_OUT <= '0;
      BAUD_DIV_OUT <= '0;
      GUARD_TIME_OUT <= '0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (wr_hit[c]) begin
          unique case (off)
            `UARTRF_OFF_IEN: ien_r[c] <= WDATA_IN & `UARTRF_IE_MASK;
            `UARTRF_OFF_FCTL: begin
              // flush is a command, never stored
              if (c == 0) begin
                fctl_r <= WDATA_IN & `UARTRF_FC_MASK & ~8'h02; // [RULE_03]
              end
            end
            `UARTRF_OFF_FMT: LINE_FORMAT_OUT[c] <= WDATA_IN;
            `UARTRF_OFF_MODE: CHANNEL_MODE_OUT[c] <= WDATA_IN & 8'hC0;
            `UARTRF_OFF_CMD: begin
              rx_en_r[c] <= WDATA_IN[`UARTRF_CMD_RXEN];
              tx_en_r[c] <= WDATA_IN[`UARTRF_CMD_TXEN];
            end
            `UARTRF_OFF_BDL: BAUD_DIV_OUT[c][7:0] <= WDATA_IN;
            `UARTRF_OFF_BDH: BAUD_DIV_OUT[c][15:8] <= WDATA_IN;
            `UARTRF_OFF_RTO: rto_r[c] <= WDATA_IN;
            `UARTRF_OFF_TTG: GUARD_TIME_OUT[c] <= WDATA_IN;
            default: ; // offset 0, offset 5 and offsets above A store nothing
          endcase
        end
      end
    end
  end
  // receive occupancy and first-set pointers
  always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      rx_cnt_r <= '0;
      wr_ptr_r <= 4'h0;
      rd_ptr_r <= 4'h0;
      hold1_r <= `UARTRF_RST_BYTE;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (rx_flush[c]) begin
          rx_cnt_r[c] <= 5'h00; // [RULE_12]
        end else begin
          rx_cnt_r[c] <= 5'(rx_cnt_r[c] + 5'(rx_push[c]) - 5'(rx_pop[c]));
        end
      end
      rd_ptr_r <= rd_ptr_nxt;
      wr_ptr_r <= rx_flush[0] ? 4'h0 : 4'(wr_ptr_r + 4'(rx_push[0]));
      if (rx_push[1]) begin
        hold1_r <= RX_DATA_IN[1];
      end
    end
  end
  // sixteen-byte receive store; read address runs one step ahead
  uartrf_mem #(.WIDTH(8), .DEPTH(16), .AW(4)) u_rx_mem (
    .clk_in(REF_CLK_IN),
    .rst_in(SYS_RST_IN),
    .we_in(rx_push[0]),
    .waddr_in(wr_ptr_r),
    .wdata_in(RX_DATA_IN[0]),
    .raddr_in(rd_ptr_nxt),
    .rdata_out(mem_q)
  );
  // transmit holding fifos; a write while full is dropped
  for (genvar g = 0; g < 2; g++) begin : g_tx
    uartrf_fifo #(.WIDTH(8), .DEPTH(4)) u_tx_fifo (
      .clk_in(REF_CLK_IN),
      .rst_in(SYS_RST_IN),
      .flush_in(tx_flush[g]),
      .in_valid_in(tx_push[g]),
      .in_data_in(WDATA_IN),
      .in_ready_out(),
      .out_valid_out(TX_VALID_OUT[g]),
      .out_data_out(TX_DATA_OUT[g]),
      .out_ready_in(TX_TAKE_IN[g]),
      .full_out(HOLD_FULL_OUT[g])
    );
  end
  // sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      {pe_r, fe_r, oe_r, brk_r, thr_rdy_r, to_flag_r} <= 12'h000;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (RX_PARITY_ERR_IN[c]) pe_r[c] <= 1'b1;
        else if (stat_clr[c]) pe_r[c] <= 1'b0; // [RULE_16]
        if (RX_FRAME_ERR_IN[c]) fe_r[c] <= 1'b1;
        else if (stat_clr[c]) fe_r[c] <= 1'b0; // [RULE_16]
        // overrun: a byte arrives with no room left
        if (RX_VALID_IN[c] && rx_full[c]) oe_r[c] <= 1'b1;
        else if (stat_clr[c]) oe_r[c] <= 1'b0; // [RULE_16]
        if (RX_BREAK_IN[c]) brk_r[c] <= 1'b1;
        else if (stat_clr[c]) brk_r[c] <= 1'b0;
        // cleared by the next holding write
        if (tx_pop[c]) thr_rdy_r[c] <= 1'b1;
        else if (tx_push[c]) thr_rdy_r[c] <= 1'b0;
        if (to_fire[c]) to_flag_r[c] <= 1'b1;
        else if (restart[c]) to_flag_r[c] <= 1'b0;
      end
    end
  end
  // timeout sequencer: rearmed by each byte or a restart command
  always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      to_state_r[0] <= uartrf_pkg::TO_IDLE;
      to_state_r[1] <= uartrf_pkg::TO_IDLE;
      to_cnt_r <= '0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (rx_push[c] || restart[c]) begin
          to_cnt_r[c] <= 8'h00;
          to_state_r[c] <= (rto_r[c] == 8'h00) ? uartrf_pkg::TO_IDLE
                                               : uartrf_pkg::TO_COUNT; // [RULE_17]
        end else begin
          unique case (to_state_r[c])
            uartrf_pkg::TO_IDLE: ;
            uartrf_pkg::TO_COUNT: begin
              // a zero limit switches the function off at once
              if (rto_r[c] == 8'h00) begin
                to_state_r[c] <= uartrf_pkg::TO_IDLE; // [RULE_17]
              end else if (to_fire[c]) begin
                to_state_r[c] <= uartrf_pkg::TO_FIRED;
              end else if (BIT_TICK_IN[c]) begin
                to_cnt_r[c] <= 8'(to_cnt_r[c] + 8'h01); // [RULE_17]
              end
            end
            uartrf_pkg::TO_FIRED: ;
          endcase
        end
      end
    end
  end
  // read multiplexer; reserved bits and unmapped offsets read zero
  always_comb begin
    rd_mux = 8'h00;
    for (int c = 0; c < 2; c++) begin
      if (hit[c]) begin
        unique case (off)
          `UARTRF_OFF_HOLD: rd_mux = (c == 0) ? mem_q : hold1_r; // [RULE_14]
          `UARTRF_OFF_IEN: rd_mux = ien_r[c];
          `UARTRF_OFF_FCTL: rd_mux = (c == 0) ? fctl_r : 8'h00; // [RULE_03]
          `UARTRF_OFF_FMT: rd_mux = LINE_FORMAT_OUT[c];
          `UARTRF_OFF_MODE: rd_mux = CHANNEL_MODE_OUT[c];
          `UARTRF_OFF_STAT: rd_mux = {tx_empty[c], to_flag_r[c], pe_r[c], fe_r[c],
                                      oe_r[c], brk_r[c], thr_rdy_r[c], rx_cnt_r[c] != 5'h00};
          `UARTRF_OFF_CMD: rd_mux = {rx_en_r[c], 1'b0, tx_en_r[c], 5'h00};
          `UARTRF_OFF_BDL: rd_mux = BAUD_DIV_OUT[c][7:0];
          `UARTRF_OFF_BDH: rd_mux = BAUD_DIV_OUT[c][15:8];
          `UARTRF_OFF_RTO: rd_mux = rto_r[c];
          `UARTRF_OFF_TTG: rd_mux = GUARD_TIME_OUT[c];
          default: rd_mux = 8'h00; // [RULE_02]
        endcase
      end
    end
  end
  // registered read data, irq requests and serial-side controls
  always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      RDATA_OUT <= 8'h00;
      IRQ_OUT <= 2'h0;
      DMA_REQ_OUT <= 1'b0;
      {RX_EN_OUT, TX_EN_OUT} <= 4'h0;
      RX_TIMEOUT_OUT <= '0;
      LINE_CMD_OUT <= '0;
    end else begin
      if (|rd_hit) begin
        RDATA_OUT <= rd_mux;
      end
      for (int c = 0; c < 2; c++) begin
        IRQ_OUT[c] <= GIE_IN && (
          (ien_r[c][`UARTRF_IE_TXEMPTY] && tx_empty[c]) || // [RULE_04]
          (ien_r[c][`UARTRF_IE_TIMEOUT] && to_flag_r[c]) || // [RULE_05]
          (ien_r[c][`UARTRF_IE_LINEERR] && (pe_r[c] || fe_r[c] || oe_r[c])) || // [RULE_06]
          (ien_r[c][`UARTRF_IE_BREAK] && brk_r[c]) || // [RULE_07]
          (ien_r[c][`UARTRF_IE_TXRDY] && thr_rdy_r[c]) || // [RULE_08]
          (ien_r[c][`UARTRF_IE_RXRDY] && rx_cause[c])); // [RULE_09]
        LINE_CMD_OUT[c] <= cmd_wr[c] ? WDATA_IN[3:0] : 4'h0;
      end
      // burst waits for the trigger fill, single moves each byte
      DMA_REQ_OUT <= fctl_r[`UARTRF_FC_DMA] ? (rx_cnt_r[0] >= trig)
                                            : (rx_cnt_r[0] != 5'h00); // [RULE_11]
      RX_EN_OUT <= rx_en_r;
      TX_EN_OUT <= tx_en_r;
      RX_TIMEOUT_OUT <= rto_r;
    end
  end
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  property p_set_decode;
    WR_IN && ADDR_IN == 16'h2051 |=> ien_r[1] == ($past(WDATA_IN) & 8'hCF);
  endproperty
  a_set_decode: assert property (p_set_decode) else $error("second set enable write lost"); // [RULE_01]
  property p_unmapped;
    RD_IN && ADDR_IN == 16'h202B |=> RDATA_OUT == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped offset read not zero"); // [RULE_02]
  property p_no_fctl1;
    RD_IN && ADDR_IN == 16'h2052 |=> RDATA_OUT == 8'h00;
  endproperty
  a_no_fctl1: assert property (p_no_fctl1) else $error("second set fifo control readable"); // [RULE_03]
  property p_txe_irq;
    GIE_IN && ien_r[0][7] && tx_empty[0] |=> IRQ_OUT[0];
  endproperty
  a_txe_irq: assert property (p_txe_irq) else $error("tx empty irq missing"); // [RULE_04]
  property p_gie_gate;
    !GIE_IN |=> !IRQ_OUT[0] && !IRQ_OUT[1];
  endproperty
  a_gie_gate: assert property (p_gie_gate) else $error("irq without global enable"); // [RULE_05]
  property p_lerr_irq;
    GIE_IN && ien_r[1][3] && (pe_r[1] || oe_r[1]) |=> IRQ_OUT[1];
  endproperty
  a_lerr_irq: assert property (p_lerr_irq) else $error("line error irq missing"); // [RULE_06]
  property p_trig;
    fctl_r[3] && fctl_r[7:6] == 2'b11 && rx_cnt_r[0] == 5'h0D |=> !DMA_REQ_OUT;
  endproperty
  a_trig: assert property (p_trig) else $error("burst request below fourteen"); // [RULE_10]
  property p_flush;
    WR_IN && ADDR_IN == 16'h2022 && WDATA_IN[1] |=> rx_cnt_r[0] == 5'h00 ##1 !DMA_REQ_OUT;
  endproperty
  a_flush: assert property (p_flush) else $error("flush left bytes"); // [RULE_12]
  property p_cap;
    !fctl_r[0] && rx_cnt_r[0] <= 5'h01 |=> rx_cnt_r[0] <= 5'h01 || fctl_r[0];
  endproperty
  a_cap: assert property (p_cap) else $error("single-character mode overfilled"); // [RULE_13]
  property p_rd_head;
    RD_IN && ADDR_IN == 16'h2020 |=> RDATA_OUT == $past(mem_q);
  endproperty
  a_rd_head: assert property (p_rd_head) else $error("holding read wrong byte"); // [RULE_14]
  property p_to_zero;
    $rose(to_flag_r[0]) |-> $past(rto_r[0]) != 8'h00;
  endproperty
  a_to_zero: assert property (p_to_zero) else $error("timeout fired while disabled"); // [RULE_17]
  c_fifo_full: cover property (fctl_r[0] && rx_cnt_r[0] == 5'h10);
  c_timeout: cover property ($rose(to_flag_r[0]));
  c_tx_full: cover property (HOLD_FULL_OUT[1]);
endmodule
`default_nettype wire

// ===== uartrf_far.sv
// model of the remote serial device facing the register file
`timescale 1ns/1ns
`default_nettype none
module uartrf_far (
  input wire logic clk_in,
  output logic [1:0][7:0] rx_data_out,
  output logic [1:0] rx_valid_out,
  output logic [1:0] perr_out,
  input wire logic [1:0][7:0] tx_data_in,
  input wire logic [1:0] tx_valid_in,
  output logic [1:0] take_out,
  output logic [7:0] last_tx_out
);
  logic [2:0] stall_r; // paces the shifter: ready one cycle in four
  initial begin
    rx_data_out = '0;
    rx_valid_out = '0;
    perr_out = '0;
    stall_r = '0;
    last_tx_out = 8'h00;
  end
  // one received byte per pulse; idle data shows the inverse so stale bytes never pass
  task automatic send(input int i, input logic [7:0] b);
    @(negedge clk_in);
    rx_data_out[i] = b;
    rx_valid_out[i] = 1'b1;
    @(negedge clk_in);
    rx_valid_out[i] = 1'b0;
    rx_data_out[i] = ~b;
  endtask
  // a single parity fault event on one lane
  task automatic fault(input int i);
    @(negedge clk_in);
    perr_out[i] = 1'b1;
    @(negedge clk_in);
    perr_out[i] = 1'b0;
  endtask
  // slow shifter: holding data must wait for it
  always @(negedge clk_in) begin
    stall_r <= stall_r + 3'h1;
    take_out <= {2{stall_r[1:0] == 2'h3}};
  end
  // capture what the shifter accepts on lane 0
  always @(posedge clk_in) begin
    if (tx_valid_in[0] && take_out[0]) begin
      last_tx_out <= tx_data_in[0];
    end
  end
endmodule
`default_nettype wire

// ===== tb_uart_register_file_irq_fifo.sv
// self-checking bench of the uart register file
`timescale 1ns/1ns
`default_nettype none
module tb_uart_register_file_irq_fifo;
  logic clk, rst, wr, rd, gie;
  logic [15:0] addr;
  logic [7:0] wdata, rdata, v, last_tx;
  uartrf_pkg::uartrf_byte_t b, q[$];
  logic [1:0][7:0] rxd, txd, gt;
  logic [1:0] rxv, perr, take, txv, irq, tick, brk;
  logic dma;
  int failures, n_compared, seed, n;
  logic [15:0] ta[6] = '{16'h2021, 16'h2051, 16'h2052, 16'h202B, 16'h202A, 16'h2058};
  logic [7:0] tw[6] = '{8'hFF, 8'hFF, 8'h01, 8'hFF, 8'h5A, 8'hA5};
  logic [7:0] te[6] = '{8'hCF, 8'hCF, 8'h00, 8'h00, 8'h5A, 8'hA5};
  uartrf_regs uut (.REF_CLK_IN(clk), .SYS_RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .GIE_IN(gie), .RDATA_OUT(rdata), .RX_DATA_IN(rxd),
    .RX_VALID_IN(rxv), .RX_PARITY_ERR_IN(perr), .RX_FRAME_ERR_IN(2'h0), .RX_BREAK_IN(brk),
    .BIT_TICK_IN(tick), .TX_SHIFT_EMPTY_IN(2'h3), .TX_TAKE_IN(take), .TX_DATA_OUT(txd),
    .TX_VALID_OUT(txv), .HOLD_FULL_OUT(), .IRQ_OUT(irq), .DMA_REQ_OUT(dma),
    .LINE_FORMAT_OUT(), .CHANNEL_MODE_OUT(), .BAUD_DIV_OUT(), .GUARD_TIME_OUT(gt),
    .RX_TIMEOUT_OUT(), .RX_EN_OUT(), .TX_EN_OUT(), .LINE_CMD_OUT());
  uartrf_far far (.clk_in(clk), .rx_data_out(rxd), .rx_valid_out(rxv), .perr_out(perr),
    .tx_data_in(txd), .tx_valid_in(txv), .take_out(take), .last_tx_out(last_tx));
  always #50 clk = ~clk;
  // fill level at which the receive request rises, per trigger code
  function automatic int trig(input int c);
    return (c == 0) ? 1 : (c == 1) ? 4 : (c == 2) ? 8 : 14;
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // one-cycle strobes, driven on the falling edge, taken on the next rising edge
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    d = rdata;
  endtask
  task automatic complete_run();
    if (failures == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    seed = 7488;
    clk = 1'b0;
    rst = 1'b1;
    {wr, rd, gie, addr, wdata, tick, brk} = '0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    gie = 1'b1;
    rd_reg(16'h2021, v);
    chk(v, 8'h00);
    rd_reg(16'h2022, v);
    chk(v, 8'h00);
    // both sets, reserved bits, missing fifo control of set 1, unmapped offset
    for (int i = 0; i < 6; i++) begin
      // software never writes the missing fifo control of set 1, only reads it
      if (ta[i] != 16'h2052) wr_reg(ta[i], tw[i]);
      rd_reg(ta[i], v);
      chk(v, te[i]);
    end
    chk(gt[0], 8'h5A);
    wr_reg(16'h2021, 8'h09);
    // every trigger code, burst and single-byte dma alternating
    for (int c = 0; c < 4; c++) begin
      wr_reg(16'h2022, {c[1:0], 2'h0, c[0], 3'h1});
      for (int k = 0; k < trig(c); k++) begin
        repeat (2) @(negedge clk);
        chk({6'h00, dma, irq[0]}, {6'h00, !c[0] && k != 0, 1'b0});
        b = 8'($random(seed));
        q.push_back(b);
        far.send(0, b);
      end
      repeat (3) @(negedge clk);
      chk({6'h00, dma, irq[0]}, 8'h03);
      while (q.size() > 0) begin
        rd_reg(16'h2020, v);
        chk(v, q.pop_front());
      end
    end
    far.send(0, 8'h3C);
    far.send(0, 8'hC3);
    wr_reg(16'h2022, 8'hFF);
    rd_reg(16'h2022, v);
    chk(v, 8'hC9);
    rd_reg(16'h2025, v);
    chk(v & 8'h01, 8'h00);
    // single-character buffer: second byte overruns
    wr_reg(16'h2022, 8'h00);
    far.send(0, 8'h5A);
    far.send(0, 8'hA5);
    rd_reg(16'h2025, v);
    chk(v & 8'h09, 8'h09);
    rd_reg(16'h2020, v);
    chk(v, 8'h5A);
    wr_reg(16'h2026, 8'h40);
    rd_reg(16'h2025, v);
    chk(v & 8'h38, 8'h00);
    far.fault(0);
    repeat (3) @(negedge clk);
    chk({7'h00, irq[0]}, 8'h01);
    gie = 1'b0;
    repeat (3) @(negedge clk);
    chk({7'h00, irq[0]}, 8'h00);
    gie = 1'b1;
    wr_reg(16'h2026, 8'h40);
    // transmit through the slow shifter
    wr_reg(16'h2021, 8'h82);
    // never zero, so it cannot match the capture's idle value before the shift
    b = 8'($random(seed)) | 8'h01;
    wr_reg(16'h2020, b);
    for (n = 0; n < 20 && last_tx !== b; n++) @(negedge clk);
    if (n == 20) failures++; // shifter never took the byte
    repeat (3) @(negedge clk);
    rd_reg(16'h2025, v);
    chk(v & 8'h82, 8'h82);
    chk({7'h00, irq[0]}, 8'h01);
    // receiver timeout of three bit periods, armed by a received byte
    wr_reg(16'h2029, 8'h03);
    wr_reg(16'h2021, 8'h40);
    far.send(0, 8'h66);
    tick = 2'h1;
    repeat (2) @(negedge clk);
    tick = 2'h0;
    repeat (2) @(negedge clk);
    chk({7'h00, irq[0]}, 8'h00);
    tick = 2'h1;
    @(negedge clk);
    tick = 2'h0;
    repeat (2) @(negedge clk);
    chk({7'h00, irq[0]}, 8'h01);
    // break condition on the receive line
    wr_reg(16'h2021, 8'h04);
    repeat (2) @(negedge clk);
    chk({7'h00, irq[0]}, 8'h00);
    brk = 2'h1;
    @(negedge clk);
    brk = 2'h0;
    repeat (2) @(negedge clk);
    chk({7'h00, irq[0]}, 8'h01);
    far.send(1, b);
    rd_reg(16'h2050, v);
    chk(v, b);
    complete_run();
  end
endmodule
`default_nettype wire
